// File: inc/fpfs_pkg.sv
`default_nettype none
package fpfs_pkg;
    // ----------------------------------------------------------------
    // Clock and bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_PS = 40_000;
    localparam int ADDR_W = 12;
    localparam int CNT_W = 18;
    typedef logic [CNT_W-1:0] fpfs_cnt_t;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] RATE_IDX = 8'h43;
    localparam logic [7:0] FMT_IDX = 8'h44;
    localparam logic [7:0] STAT_IDX = 8'h50;
    localparam logic [ADDR_W-1:0] RATE_ADDR = {2'h0, RATE_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] FMT_ADDR = {2'h0, FMT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
    localparam logic [7:0] RATE_RST = 8'h05;
    localparam logic [7:0] FMT_RST = 8'h11;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RATE_LSB = 0;
    localparam int STYLE_BIT = 0;
    localparam int EDGE_BIT = 1;
    localparam int WIDTH_LSB = 4;
    localparam int POL_BIT = 7;
    localparam logic [2:0] WIDTH_MAXDEF = 3'h4;
    localparam logic [2:0] WIDTH_SYNC = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Timing: repetition rates in millihertz, widths in picoseconds
    // ----------------------------------------------------------------
    localparam longint unsigned RATE_MHZ [8] = '{64'd166670, 64'd400000, 64'd1000000,
        64'd2000000, 64'd4000000, 64'd8000000, 64'd32000000, 64'd64000000};
    localparam longint unsigned WIDTH_PS [5] = '{64'd244141, 64'd122070, 64'd61035,
        64'd30518, 64'd15259};

    function automatic int unsigned period_cycles(input int code);
        longint unsigned c;
        c = (longint'(CLK_HZ) * 64'd1000) / RATE_MHZ[code];
        return int'(c);
    endfunction

    // A pulse width is a least time, so it rounds up, never below one cycle.
    function automatic fpfs_cnt_t width_cycles(input int code);
        longint unsigned c;
        c = (WIDTH_PS[code] + longint'(CLK_PS) - 64'd1) / longint'(CLK_PS);
        if (c < 64'd1) begin
            c = 64'd1;
        end
        return fpfs_cnt_t'(c);
    endfunction

    typedef enum logic [1:0] {
        FPFS_IDLE = 2'b00,
        FPFS_WAIT = 2'b01,
        FPFS_ACTIVE = 2'b10
    } fpfs_state_e;
endpackage
`default_nettype wire

// File: inc/fpfs_seq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fpfs_seq_if;
    import fpfs_pkg::*;
    logic start;
    fpfs_cnt_t load;
    logic done;
    logic falling_sel;
    logic launch;
    modport ctrl (output start, output load, output falling_sel, input done, input launch);
    modport timer (input start, input load, output done);
    modport edge_det (input falling_sel, output launch);
endinterface
`default_nettype wire

// File: rtl/fpfs_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module fpfs_edge_detect (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sampled synthesizer clock
    input wire logic sync_level,
    // Launch strobe towards the sequencer
    fpfs_seq_if.edge_det seq
);
    import fpfs_pkg::*;
    logic prev_reg;
    logic primed_reg;

    // Previous sample; no edge is claimed until one real sample is held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg <= sync_level;
            primed_reg <= 1'b1;
        end
    end

    // Pick the rising or the falling edge of the synchronization clock.
    assign seq.launch = primed_reg & (seq.falling_sel ? (prev_reg & ~sync_level)
                                                      : (~prev_reg & sync_level));
endmodule // fpfs_edge_detect
`default_nettype wire

// File: rtl/fpfs_width_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fpfs_width_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Start, length and done
    fpfs_seq_if.timer seq
);
    import fpfs_pkg::*;
    fpfs_cnt_t cnt_reg;

    // Loaded with the length on start; done marks the last active cycle.
    // An empty counter also reads as done, so a pulse whose width code is changed
    // from the edge-timed code to a fixed one while it runs cannot hang.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else if (seq.start) begin
            cnt_reg <= seq.load;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - fpfs_cnt_t'(1);
        end
    end

    assign seq.done = (cnt_reg <= fpfs_cnt_t'(1));
endmodule // fpfs_width_timer
`default_nettype wire

// File: rtl/fpfs_pulse_top.sv
// Operation
// - Rate code picks one of eight repetition rates.
// - Style bit: 50% clock or frame pulse.
// - Edge bit picks rising or falling launch edge.
// - Width codes 0-4 give fixed pulse lengths.
// - Width code 7 lasts one synthesizer clock cycle.
// - Polarity bit inverts the output pulse.
`timescale 1ns/10ps
`default_nettype none
module fpfs_pulse_top #(
    parameter int unsigned PER_C0 = fpfs_pkg::period_cycles(0),
    parameter int unsigned PER_C1 = fpfs_pkg::period_cycles(1),
    parameter int unsigned PER_C2 = fpfs_pkg::period_cycles(2),
    parameter int unsigned PER_C3 = fpfs_pkg::period_cycles(3),
    parameter int unsigned PER_C4 = fpfs_pkg::period_cycles(4)
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [fpfs_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [fpfs_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Synthesizer clock and frame pulse output
    input wire logic synth_clock_out_b,
    output logic frame_pulse_out_b
);
    import fpfs_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    localparam int unsigned PER_MAX = 2 ** CNT_W;
    if (PER_C0 >= PER_MAX || PER_C1 >= PER_MAX || PER_C2 >= PER_MAX ||
        PER_C3 >= PER_MAX || PER_C4 >= PER_MAX) begin : g_chk_big
        $error("Frame period does not fit the counter.");
    end
    if (PER_C0 < 2 || PER_C1 < 2 || PER_C2 < 2 || PER_C3 < 2 || PER_C4 < 2) begin : g_chk_small
        $error("Frame period needs two cycles at least.");
    end

    // ----------------------------------------------------------------
    // Lookup tables
    // ----------------------------------------------------------------
    localparam fpfs_cnt_t PER_TAB [8] = '{fpfs_cnt_t'(PER_C0), fpfs_cnt_t'(PER_C1),
        fpfs_cnt_t'(PER_C2), fpfs_cnt_t'(PER_C3), fpfs_cnt_t'(PER_C4),
        fpfs_cnt_t'(period_cycles(5)), fpfs_cnt_t'(period_cycles(6)),
        fpfs_cnt_t'(period_cycles(7))};
    localparam fpfs_cnt_t WID_TAB [5] = '{width_cycles(0), width_cycles(1),
        width_cycles(2), width_cycles(3), width_cycles(4)};

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] rate_reg, fmt_reg, wbyte_reg;
    logic aw_held_reg, w_held_reg, wlane_reg, bvalid_reg, rvalid_reg, do_write;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [2:0] pulse_rate_code, pulse_width_code, width_eff;
    logic waveform_style_bit, launch_edge_bit, pulse_polarity_bit, sync_mode;
    fpfs_cnt_t period_sel, per_cnt_reg, per_len_reg, act_cnt_reg, act_len_reg;
    logic frame_tick, clk_level, pulse_level, fp_out_reg;
    fpfs_state_e state_reg, state_next;

    fpfs_seq_if seq ();

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Address and data are each held until both are in, so either order works.
    assign awready = ~aw_held_reg & ~bvalid_reg;
    assign wready = ~w_held_reg & ~bvalid_reg;
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = ~rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // Capture of the write address and write data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wbyte_reg <= wdata[7:0];
                wlane_reg <= wstrb[0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response; unmapped words answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            if (awaddr_reg[ADDR_W-1:2] == RATE_ADDR[ADDR_W-1:2] ||
                awaddr_reg[ADDR_W-1:2] == FMT_ADDR[ADDR_W-1:2] ||
                awaddr_reg[ADDR_W-1:2] == STAT_ADDR[ADDR_W-1:2]) begin
                bresp_reg <= RESP_OKAY;
            end else begin
                bresp_reg <= RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // The two format registers; reserved bits are stored as written.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_reg <= RATE_RST;
            fmt_reg <= FMT_RST;
        end else if (do_write && wlane_reg) begin
            if (awaddr_reg[ADDR_W-1:2] == RATE_ADDR[ADDR_W-1:2]) begin
                rate_reg <= wbyte_reg;
            end
            if (awaddr_reg[ADDR_W-1:2] == FMT_ADDR[ADDR_W-1:2]) begin
                fmt_reg <= wbyte_reg;
            end
        end
    end

    // Read channel; the status word shows the sequencer state and output.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            if (araddr[ADDR_W-1:2] == RATE_ADDR[ADDR_W-1:2]) begin
                rdata_reg <= {24'h000000, rate_reg};
            end else if (araddr[ADDR_W-1:2] == FMT_ADDR[ADDR_W-1:2]) begin
                rdata_reg <= {24'h000000, fmt_reg};
            end else if (araddr[ADDR_W-1:2] == STAT_ADDR[ADDR_W-1:2]) begin
                rdata_reg <= {29'h00000000, fp_out_reg, state_reg};
            end else begin
                rdata_reg <= 32'h00000000;
                rresp_reg <= RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    assign pulse_rate_code = rate_reg[RATE_LSB +: 3];
    assign waveform_style_bit = fmt_reg[STYLE_BIT];
    assign launch_edge_bit = fmt_reg[EDGE_BIT];
    assign pulse_width_code = fmt_reg[WIDTH_LSB +: 3];
    assign pulse_polarity_bit = fmt_reg[POL_BIT];
    assign sync_mode = (pulse_width_code == WIDTH_SYNC);
    // Reserved width codes fall back to the shortest fixed width.
    assign width_eff = (pulse_width_code > WIDTH_MAXDEF) ? WIDTH_MAXDEF
                                                         : pulse_width_code;
    assign period_sel = PER_TAB[pulse_rate_code];

    // ----------------------------------------------------------------
    // Frame period and clock-style waveform
    // ----------------------------------------------------------------
    // A rate change takes effect at the next wrap, so no period is cut short.
    // The period is latched with it, so the half-way mark cannot move mid-period.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt_reg <= '0;
            per_len_reg <= '1;
        end else if (per_cnt_reg == '0) begin
            per_cnt_reg <= period_sel - fpfs_cnt_t'(1);
            per_len_reg <= period_sel;
        end else begin
            per_cnt_reg <= per_cnt_reg - fpfs_cnt_t'(1);
        end
    end

    assign frame_tick = (per_cnt_reg == '0);
    assign clk_level = (per_cnt_reg >= (per_len_reg >> 1));

    // ----------------------------------------------------------------
    // Frame pulse sequencer
    // ----------------------------------------------------------------
    assign seq.falling_sel = launch_edge_bit;
    assign seq.start = (state_reg == FPFS_WAIT) && seq.launch && !sync_mode;
    assign seq.load = WID_TAB[width_eff];

    // The pulse waits for the chosen edge; a stopped synthesizer clock holds it.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FPFS_IDLE: begin
                if (waveform_style_bit && frame_tick) begin
                    state_next = FPFS_WAIT;
                end
            end
            FPFS_WAIT: begin
                if (!waveform_style_bit) begin
                    state_next = FPFS_IDLE;
                end else if (seq.launch) begin
                    state_next = FPFS_ACTIVE;
                end
            end
            FPFS_ACTIVE: begin
                if (!waveform_style_bit || (sync_mode ? seq.launch : seq.done)) begin
                    state_next = FPFS_IDLE;
                end
            end
            default: begin
                state_next = FPFS_IDLE;
            end
        endcase
    end

    // Sequencer state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= FPFS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Output flop keeps the pin free of decode glitches.
    assign pulse_level = waveform_style_bit ? (state_reg == FPFS_ACTIVE) : clk_level;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fp_out_reg <= 1'b0;
        end else begin
            fp_out_reg <= pulse_level ^ pulse_polarity_bit;
        end
    end
    assign frame_pulse_out_b = fp_out_reg;

    fpfs_edge_detect u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .sync_level(synth_clock_out_b),
        .seq(seq.edge_det)
    );

    fpfs_width_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .seq(seq.timer)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles spent in the active state and the length given at launch, read only by the checks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_cnt_reg <= '0;
            act_len_reg <= '0;
        end else if (state_reg == FPFS_ACTIVE) begin
            act_cnt_reg <= act_cnt_reg + fpfs_cnt_t'(1);
        end else begin
            act_cnt_reg <= '0;
            act_len_reg <= seq.start ? WID_TAB[width_eff] : '0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rate_reload_a: assert property (frame_tick |=> per_cnt_reg == $past(period_sel) - 1)
        else $error("Frame counter reloaded with wrong period.");
    clk_duty_a: assert property (!waveform_style_bit &&
        per_cnt_reg == (per_len_reg >> 1) |=> frame_pulse_out_b == !$past(pulse_polarity_bit))
        else $error("Clock style high half wrong.");
    clk_idle_a: assert property (!waveform_style_bit |=> state_reg != FPFS_ACTIVE)
        else $error("Frame pulse active in clock style.");
    launch_edge_a: assert property (state_reg == FPFS_WAIT && waveform_style_bit &&
        seq.launch |-> (launch_edge_bit ? $fell(synth_clock_out_b) : $rose(synth_clock_out_b))
        ##1 state_reg == FPFS_ACTIVE)
        else $error("Pulse not launched on selected edge.");
    no_launch_a: assert property (state_reg == FPFS_WAIT && !seq.launch &&
        waveform_style_bit |=> state_reg == FPFS_WAIT)
        else $error("Pulse launched without edge.");
    width_len_a: assert property (state_reg == FPFS_ACTIVE && state_next == FPFS_IDLE &&
        !sync_mode && waveform_style_bit && act_len_reg != '0 |-> act_cnt_reg + 1 == act_len_reg)
        else $error("Fixed pulse width wrong.");
    sync_width_a: assert property (state_reg == FPFS_ACTIVE && sync_mode && seq.launch
        |=> state_reg == FPFS_IDLE)
        else $error("Sync width pulse did not end on edge.");
    polarity_a: assert property (state_reg == FPFS_IDLE && waveform_style_bit |=>
        frame_pulse_out_b == $past(pulse_polarity_bit))
        else $error("Idle level disagrees with polarity.");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped early.");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("Read data dropped early.");

    clk_wrap_c: cover property (!waveform_style_bit && frame_tick);
    timer_end_c: cover property (state_reg == FPFS_ACTIVE && !sync_mode ##1 state_reg == FPFS_IDLE);
    sync_end_c: cover property (state_reg == FPFS_ACTIVE && sync_mode ##1 state_reg == FPFS_IDLE);
    write_c: cover property (bvalid && bready && bresp == RESP_OKAY);
endmodule // fpfs_pulse_top
`default_nettype wire

// File: testbench/fpfs_pulse_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module fpfs_pulse_top_test;
    import fpfs_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    localparam int SYNTH_HALF = 5;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic synth = 1'h0;
    logic [3:0] sdiv = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    wire logic awready, wready, bvalid, arready, rvalid, fp;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int n_fail = 0;
    int checks_done = 0;
    // Periods match the shortened top parameters for codes 0 to 4.
    int unsigned per_tab [8] = '{40, 32, 24, 20, 16, 3125, 781, 390};

    fpfs_pulse_top #(.PER_C0(40), .PER_C1(32), .PER_C2(24), .PER_C3(20), .PER_C4(16)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .synth_clock_out_b(synth), .frame_pulse_out_b(fp)
    );

    // Clock generator.
    initial begin
        forever #20 aclk = ~aclk;
    end

    // Synthesizer clock, ten bus cycles a period, so every launch edge is well apart.
    always @(posedge aclk) begin
        if (sdiv == 4'(SYNTH_HALF - 1)) begin
            sdiv <= 4'h0;
            synth <= ~synth;
        end else begin
            sdiv <= sdiv + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Pulse length in bus cycles for width codes 0 to 4, rounded up.
    function automatic int w_exp(input int c);
        longint d;
        d = 64'd163840000000 << c;
        return int'((64'd1000000000000 + d - 64'd1) / d);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Each channel is released at the edge that takes it, never earlier.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (bvalid !== 1'h1) @(posedge aclk);
        r = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    // Measures one active phase and the idle phase after it, sampled mid-cycle.
    task automatic pulse(input logic act, output int w, output int w2, output logic s);
        w = 0;
        w2 = 0;
        @(negedge aclk);
        while (fp !== !act) @(negedge aclk);
        while (fp !== act) @(negedge aclk);
        s = synth;
        while (fp === act) begin w++; @(negedge aclk); end
        while (fp === !act) begin w2++; @(negedge aclk); end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hang anywhere ends the run as a failure; the tests need about 20k cycles.
    initial begin
        repeat (60000) @(posedge aclk);
        $display("watchdog expired");
        n_fail++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic s, e, p;
        int w, w2, c, k;
        void'($urandom(19359));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        // Defaults: frame style, rising edge, width code 1, positive.
        rd(RATE_ADDR, d, r);
        chk(d, 32'h05);
        rd(FMT_ADDR, d, r);
        chk(d, 32'h11);
        pulse(1'h1, w, w2, s);
        chk(w, w_exp(1));
        chk(s, 1'h1);
        rd(12'h000, d, r);
        chk(r, RESP_SLVERR);
        wr(12'h004, 32'hFF, r);
        chk(r, RESP_SLVERR);
        $display("test defaults done");
        // Clock style over every rate code; upper data bits are noise the block drops.
        wr(FMT_ADDR, 32'h00, r);
        rd(STAT_ADDR, d, r);
        chk({r, d[1:0]}, {RESP_OKAY, 2'h0});
        wr(STAT_ADDR, 32'h07, r);
        chk(r, RESP_OKAY);
        for (c = 0; c < 8; c++) begin
            wr(RATE_ADDR, ($urandom() & 32'hFFFF_FF00) | 32'(c), r);
            rd(RATE_ADDR, d, r);
            chk(d, 32'(c));
            pulse(1'h1, w, w2, s);
            chk(w, per_tab[c] - per_tab[c] / 2);
            chk(w + w2, per_tab[c]);
        end
        wr(FMT_ADDR, 32'h80, r);
        pulse(1'h0, w, w2, s);
        chk(w, per_tab[7] - per_tab[7] / 2);
        // A write with byte 0 disabled must leave the rate alone.
        @(posedge aclk);
        wstrb <= 4'h0;
        wr(RATE_ADDR, 32'h02, r);
        wstrb <= 4'hF;
        rd(RATE_ADDR, d, r);
        chk(d, 32'h07);
        $display("test clock style done");
        // Frame style: widths 0 to 4, 7 and reserved 5, both edges, both polarities.
        wr(RATE_ADDR, 32'h00, r);
        for (k = 0; k < 7; k++) begin
            c = (k == 5) ? 7 : ((k == 6) ? 5 : k);
            e = k[0];
            p = k[1];
            d = ($urandom() & 32'hFFFF_FF00) | {24'h0, p, 3'(c), 2'h0, e, 1'h1};
            wr(FMT_ADDR, d, r);
            // The first pulse may be cut by the format change, so the second is judged.
            pulse(!p, w, w2, s);
            pulse(!p, w, w2, s);
            chk(w, (c == 7) ? 2 * SYNTH_HALF : w_exp((c > 4) ? 4 : c));
            chk(s, !e);
        end
        $display("test frame style done");
        report_and_stop();
    end
endmodule // fpfs_pulse_top_test
`default_nettype wire
